// ### hw/dvr_regs.svh
// register map, field positions, reset values and codes of the volume ramp block
`ifndef DVR_REGS_SVH
`define DVR_REGS_SVH

// register indices; byte address is four times the index
`define DVR_IDX_CLK_STATUS    10'h039
`define DVR_IDX_VOL_LEVEL     10'h04c
`define DVR_IDX_RAMP_SET      10'h04e
`define DVR_IDX_EMERG_RAMP    10'h04f
`define DVR_IDX_IRQ_STATUS    10'h060
`define DVR_IDX_IRQ_MASK      10'h061
`define DVR_IDX_FS_CTRL       10'h062

// reset values
`define DVR_RST_CLK_STATUS    8'h00
`define DVR_RST_VOL_LEVEL     8'h30
`define DVR_RST_RAMP_SET      8'h33
`define DVR_RST_EMERG_RAMP    8'h30
`define DVR_RST_FS_CTRL       8'h00
`define DVR_RST_IRQ           7'h00

// codes
`define DVR_CODE_MUTE         8'hff
`define DVR_RATE_INSTANT      2'h3
`define DVR_BCLK_RATIO_MIN    9'h020
`define DVR_BCLK_RATIO_MAX    10'h200
`define DVR_FS_ERROR          4'h0

// field positions
`define DVR_IRQ_RAMP_DONE     6
`define DVR_FS_IGNORE_BIT     4

`endif

// ### hw/dvr_pkg.sv
// types shared by the volume ramp block
package dvr_pkg;

  typedef enum logic [2:0] {
    RAMP_IDLE = 3'b001,
    RAMP_FALL = 3'b010,
    RAMP_RISE = 3'b100
  } dvr_ramp_state_t;

  typedef struct packed {
    logic [7:0]      vol;
    logic [7:0]      ramp_set;
    logic [7:0]      emerg_set;
    logic [7:0]      fs_ctrl;
    logic [1:0]      status_rsv;
    logic [5:0]      flags;
    logic [6:0]      irq_stat;
    logic [6:0]      irq_mask;
    logic [7:0]      cur;
    logic [1:0]      div;
    dvr_ramp_state_t state;
    logic            mute;
    logic            active;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic            irq;
  } dvr_state_t;

endpackage

// ### hw/dvr_volume_ramp.sv
// digital volume ramp with clock monitor flags and apb register slave
`timescale 1ns/1ps
`include "dvr_regs.svh"

// Summary of operation
// - code 0 is +24 dB, each step -0.5 dB, 0xfe is -103 dB, 0xff mutes.
// - one volume code drives left and right channels alike.
// - volume code resets to 0x30, unity gain.
// - falling gain updates every 1, 2 or 4 sample periods; code 3 jumps at once.
// - falling gain steps 4, 2, 1 or 0.5 dB per update; default 0.5 dB.
// - rising gain updates every 1, 2 or 4 sample periods; code 3 restores at once.
// - rising gain steps 4, 2, 1 or 0.5 dB per update; default 0.5 dB.
// - missing or out-of-range bit clock, sample-rate error (unless ignored) or power loss ramps down with separate emergency rate and step.
// - status bit 5 shows bit clock over or under rate.
// - status bit 4 shows pll overrate.
// - status bit 3 shows pll lock, reads unlocked while pll is disabled.
// - status bit 2 shows bit clock missing.
// - status bit 1 valid only when ratio stable and within 32 to 512.
// - status bit 0: rate invalid in auto mode, else configured/detected mismatch.
// - sample-rate error flag rises even when its ignore setting is on.
module dvr_volume_ramp (
  // clock, reset, enable
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // sample timing and clock monitors
  input  wire logic        fs_tick_i,
  input  wire logic        bclk_rate_err_i,
  input  wire logic        pll_overrate_i,
  input  wire logic        pll_lock_i,
  input  wire logic        pll_enable_i,
  input  wire logic        bclk_missing_i,
  input  wire logic        bclk_ratio_stable_i,
  input  wire logic [9:0]  bclk_ratio_i,
  input  wire logic [3:0]  fs_detected_i,
  input  wire logic        power_loss_i,
  // volume and interrupt
  output logic      [7:0]  volume_code_o,
  output logic             mute_o,
  output logic             ramp_active_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dvr_pkg::dvr_state_t st_reg;
  dvr_pkg::dvr_state_t st_next;

  logic        ratio_ok;
  logic        fs_auto;
  logic        fs_err;
  logic        emerg;
  logic [7:0]  target;
  logic        falling;
  logic [1:0]  rate;
  logic [1:0]  step_code;
  logic [8:0]  step;
  logic [1:0]  last_div;
  logic [8:0]  sum_up;
  logic [8:0]  lim_down;
  logic [5:0]  flag_evt;
  logic        done_evt;
  logic        setup;
  logic        done_acc;
  logic [9:0]  idx;
  logic        aligned;
  logic        mapped;
  logic [7:0]  rd_byte;
  logic [6:0]  w1c;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;

    // clock monitor flags
    ratio_ok = bclk_ratio_stable_i
               && (bclk_ratio_i >= {1'b0, `DVR_BCLK_RATIO_MIN})
               && (bclk_ratio_i <= `DVR_BCLK_RATIO_MAX);
    fs_auto  = (st_reg.fs_ctrl[3:0] == `DVR_FS_ERROR);
    fs_err   = fs_auto ? (fs_detected_i == `DVR_FS_ERROR)
                       : (fs_detected_i != st_reg.fs_ctrl[3:0]);
    st_next.flags = {bclk_rate_err_i,
                     pll_overrate_i,
                     pll_lock_i & pll_enable_i,
                     bclk_missing_i,
                     ratio_ok,
                     fs_err};
    flag_evt = st_next.flags ^ st_reg.flags;

    // the ignore bit only keeps a rate error from forcing an emergency ramp
    emerg = power_loss_i | bclk_missing_i | ~ratio_ok
            | (fs_err & ~st_reg.fs_ctrl[`DVR_FS_IGNORE_BIT]);

    // one code for both channels; larger code means lower gain
    target  = emerg ? `DVR_CODE_MUTE : st_reg.vol;
    falling = (target > st_reg.cur);
    if (falling && emerg)
    begin
      rate      = st_reg.emerg_set[7:6];
      step_code = st_reg.emerg_set[5:4];
    end
    else if (falling)
    begin
      rate      = st_reg.ramp_set[7:6];
      step_code = st_reg.ramp_set[5:4];
    end
    else
    begin
      rate      = st_reg.ramp_set[3:2];
      step_code = st_reg.ramp_set[1:0];
    end

    // step in half-dB code units: 4, 2, 1, 0.5 dB
    unique case (step_code)
      2'h0:    step = 9'h008;
      2'h1:    step = 9'h004;
      2'h2:    step = 9'h002;
      2'h3:    step = 9'h001;
    endcase
    unique case (rate)
      2'h0:    last_div = 2'h0;
      2'h1:    last_div = 2'h1;
      2'h2:    last_div = 2'h3;
      2'h3:    last_div = 2'h0;
    endcase

    sum_up   = {1'b0, st_reg.cur} + step;
    lim_down = {1'b0, target} + step;

    // ramp engine
    done_evt = 1'b0;
    unique case (st_reg.state)
      dvr_pkg::RAMP_IDLE:
      begin
        st_next.div = 2'h0;
        if (target != st_reg.cur)
        begin
          st_next.state = falling ? dvr_pkg::RAMP_FALL : dvr_pkg::RAMP_RISE;
        end
      end
      dvr_pkg::RAMP_FALL,
      dvr_pkg::RAMP_RISE:
      begin
        if (target == st_reg.cur)
        begin
          st_next.state = dvr_pkg::RAMP_IDLE;
          st_next.div   = 2'h0;
        end
        else if (falling != (st_reg.state == dvr_pkg::RAMP_FALL))
        begin
          // direction reversed: restart the update interval
          st_next.state = falling ? dvr_pkg::RAMP_FALL : dvr_pkg::RAMP_RISE;
          st_next.div   = 2'h0;
        end
        else if (fs_tick_i)
        begin
          if (rate == `DVR_RATE_INSTANT)
          begin
            st_next.cur = target;
          end
          else if (st_reg.div == last_div)
          begin
            st_next.div = 2'h0;
            if (falling)
            begin
              st_next.cur = (sum_up >= {1'b0, target}) ? target
                                                       : sum_up[7:0];
            end
            else
            begin
              st_next.cur = ({1'b0, st_reg.cur} <= lim_down) ? target
                                                             : 8'(st_reg.cur - step[7:0]);
            end
          end
          else
          begin
            st_next.div = st_reg.div + 2'h1;
          end
          done_evt = (st_next.cur == target);
        end
      end
      default:
      begin
        st_next.state = dvr_pkg::RAMP_IDLE;
        st_next.div   = 2'h0;
      end
    endcase
    st_next.mute = (st_next.cur == `DVR_CODE_MUTE);
    // registered copy so the ramp flag leaves straight from a flop
    st_next.active = (st_next.state != dvr_pkg::RAMP_IDLE);

    // apb slave: one wait state, answer registered
    setup    = psel_i & penable_i & ~st_reg.pready;
    done_acc = psel_i & penable_i & st_reg.pready;
    idx      = paddr_i[11:2];
    aligned  = (paddr_i[1:0] == 2'h0);
    mapped   = aligned && ((idx == `DVR_IDX_CLK_STATUS) || (idx == `DVR_IDX_VOL_LEVEL)
               || (idx == `DVR_IDX_RAMP_SET) || (idx == `DVR_IDX_EMERG_RAMP)
               || (idx == `DVR_IDX_IRQ_STATUS) || (idx == `DVR_IDX_IRQ_MASK)
               || (idx == `DVR_IDX_FS_CTRL));
    rd_byte  = 8'h00;
    if (aligned)
    begin
      unique case (idx)
        `DVR_IDX_CLK_STATUS: rd_byte = {st_reg.status_rsv, st_reg.flags};
        `DVR_IDX_VOL_LEVEL:  rd_byte = st_reg.vol;
        `DVR_IDX_RAMP_SET:   rd_byte = st_reg.ramp_set;
        `DVR_IDX_EMERG_RAMP: rd_byte = st_reg.emerg_set;
        `DVR_IDX_IRQ_STATUS: rd_byte = {1'b0, st_reg.irq_stat};
        `DVR_IDX_IRQ_MASK:   rd_byte = {1'b0, st_reg.irq_mask};
        `DVR_IDX_FS_CTRL:    rd_byte = st_reg.fs_ctrl;
        default:             rd_byte = 8'h00;
      endcase
    end
    st_next.pready  = setup;
    st_next.pslverr = setup & ~mapped;
    st_next.prdata  = setup ? {24'h000000, rd_byte} : 32'h00000000;

    w1c = 7'h00;
    if (done_acc && pwrite_i && aligned)
    begin
      unique case (idx)
        `DVR_IDX_CLK_STATUS: st_next.status_rsv = pwdata_i[7:6];
        `DVR_IDX_VOL_LEVEL:  st_next.vol        = pwdata_i[7:0];
        `DVR_IDX_RAMP_SET:   st_next.ramp_set   = pwdata_i[7:0];
        `DVR_IDX_EMERG_RAMP: st_next.emerg_set  = {pwdata_i[7:4], 4'h0};
        `DVR_IDX_IRQ_STATUS: w1c                = pwdata_i[6:0];
        `DVR_IDX_IRQ_MASK:   st_next.irq_mask   = pwdata_i[6:0];
        `DVR_IDX_FS_CTRL:    st_next.fs_ctrl    = {3'h0, pwdata_i[4:0]};
        default:             w1c                = 7'h00;
      endcase
    end

    // ----------------------------------------------------------------
    // interrupts: new events win over a same-cycle clear
    // ----------------------------------------------------------------
    st_next.irq_stat = (st_reg.irq_stat & ~w1c) | {done_evt, flag_evt};
    st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      st_reg            <= '0;
      st_reg.vol        <= `DVR_RST_VOL_LEVEL;
      st_reg.ramp_set   <= `DVR_RST_RAMP_SET;
      st_reg.emerg_set  <= `DVR_RST_EMERG_RAMP;
      st_reg.fs_ctrl    <= `DVR_RST_FS_CTRL;
      st_reg.cur        <= `DVR_RST_VOL_LEVEL;
      st_reg.irq_stat   <= `DVR_RST_IRQ;
      st_reg.irq_mask   <= `DVR_RST_IRQ;
      st_reg.state      <= dvr_pkg::RAMP_IDLE;
    end
    else if (ce_i)
    begin
      st_reg <= st_next;
    end
  end

  assign prdata_o      = st_reg.prdata;
  assign pready_o      = st_reg.pready;
  assign pslverr_o     = st_reg.pslverr;
  assign volume_code_o = st_reg.cur;
  assign mute_o        = st_reg.mute;
  assign ramp_active_o = st_reg.active;
  assign irq_o         = st_reg.irq;

endmodule // dvr_volume_ramp

// ### tb/dvr_volume_ramp_properties.sv
// port checker of the volume ramp block
`timescale 1ns/1ps
module dvr_volume_ramp_chk (
  // watched ports
  input wire logic        sys_clk_i,
  input wire logic        srst_i,
  input wire logic        ce_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        fs_tick_i,
  input wire logic        pll_enable_i,
  input wire logic [7:0]  volume_code_o,
  input wire logic        mute_o,
  input wire logic        ramp_active_o
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  mute_tracks_a: assert property (mute_o == (volume_code_o == 8'hff))
    else $error("mute flag disagrees with code");
  one_wait_a: assert property (psel_i && penable_i && !pready_o && ce_i |=> pready_o)
    else $error("apb answer not after one wait");
  ready_pulse_a: assert property (pready_o && ce_i |=> !pready_o)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  rdata_quiet_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  unmapped_err_a: assert property (pready_o && paddr_i == 12'h0e8 |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  tick_paced_a: assert property (!fs_tick_i && !srst_i |=> $stable(volume_code_o))
    else $error("volume moved without sample tick");
  idle_hold_a: assert property (!ramp_active_o |=> $stable(volume_code_o))
    else $error("volume moved while idle");
  pll_off_a: assert property (pready_o && !pslverr_o && paddr_i == 12'h0e4 &&
    !$past(pll_enable_i) && !$past(pll_enable_i, 2) |-> !prdata_o[3])
    else $error("pll shown locked while disabled");

  cover property (pready_o && pslverr_o);
  cover property (mute_o);
  cover property (ramp_active_o && fs_tick_i);
endmodule // dvr_volume_ramp_chk

bind dvr_volume_ramp dvr_volume_ramp_chk u_chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .fs_tick_i(fs_tick_i), .pll_enable_i(pll_enable_i),
  .volume_code_o(volume_code_o), .mute_o(mute_o), .ramp_active_o(ramp_active_o)
);

// ### tb/tb.sv
// self-checking testbench of the volume ramp block
`timescale 1ns/1ps
module tb;
  logic        sys_clk_i     = 1'b0;
  logic        srst_i        = 1'b1;
  logic        ce_i          = 1'b1;
  logic [7:0]  vfrz;
  logic        psel_i        = 1'b0;
  logic        penable_i     = 1'b0;
  logic        pwrite_i      = 1'b0;
  logic [11:0] paddr_i       = 12'h000;
  logic [31:0] pwdata_i      = 32'h0;
  logic        power_loss_i  = 1'b0;
  logic [5:0]  mon           = 6'h0d;
  logic [9:0]  bclk_ratio_i  = 10'h040;
  logic [3:0]  fs_detected_i = 4'h9;
  logic [2:0]  div           = 3'h0;
  logic        fs_tick_i;
  logic [31:0] prdata_o;
  logic [31:0] rdat;
  logic [7:0]  volume_code_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        serr;
  logic        mute_o;
  logic        ramp_active_o;
  logic        irq_o;
  int          ticks;
  int          err_total;
  int          samples_checked;

  initial
  begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // a sample period of eight clocks keeps long ramps short
  assign fs_tick_i = (div == 3'h7);
  always @(posedge sys_clk_i)
  begin
    div <= div + 3'h1;
    if (ramp_active_o === 1'b1 && fs_tick_i)
      ticks <= ticks + 1;
  end

  dvr_volume_ramp dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .fs_tick_i(fs_tick_i),
    .bclk_rate_err_i(mon[5]), .pll_overrate_i(mon[4]), .pll_lock_i(mon[3]),
    .pll_enable_i(mon[2]), .bclk_missing_i(mon[1]), .bclk_ratio_stable_i(mon[0]),
    .bclk_ratio_i(bclk_ratio_i), .fs_detected_i(fs_detected_i), .power_loss_i(power_loss_i),
    .volume_code_o(volume_code_o), .mute_o(mute_o), .ramp_active_o(ramp_active_o),
    .irq_o(irq_o)
  );

  // ----------------------------------------
  // bus cycles and comparison
  // ----------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stall(input int n);
    if (n >= 4000)
    begin
      err_total++;
      $display("ERROR timeout expected 0 seen %0d", n);
      conclude();
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 4000);
    stall(n);
    rdat = prdata_o;
    serr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check("read data", rdat, {24'h0, exp});
  endtask

  // writes ramp settings and level, then waits for the ramp to settle
  task automatic ramp(input logic [7:0] rs, input logic [7:0] lvl, input logic pl,
                      input logic [7:0] tgt, input int nt);
    int n;
    n = 0;
    apb(1'b1, 12'h138, rs);
    ticks = 0;
    power_loss_i <= pl;
    apb(1'b1, 12'h130, lvl);
    repeat (2) @(posedge sys_clk_i);
    while (ramp_active_o !== 1'b0 && n < 4000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    stall(n);
    check("volume", {24'h0, volume_code_o}, {24'h0, tgt});
    check("ticks", ticks, nt);
    check("mute", {31'h0, mute_o}, {31'h0, tgt == 8'hff});
  endtask

  task automatic flags(input logic [5:0] m, input logic [9:0] r, input logic [3:0] f,
                       input logic [7:0] fc, input logic [7:0] exp);
    mon <= m;
    bclk_ratio_i <= r;
    fs_detected_i <= f;
    apb(1'b1, 12'h188, fc);
    rd(12'h0e4, exp);
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rd(12'h130, 8'h30);
    rd(12'h138, 8'h33);
    rd(12'h13c, 8'h30);
    rd(12'h0e4, 8'h0a);
    rd(12'h180, 8'h0a);
    rd(12'h0e8, 8'h00);
    check("slverr", {31'h0, serr}, 32'h1);
    apb(1'b1, 12'h184, 8'h40);
    apb(1'b1, 12'h180, 8'h7f);
    rd(12'h180, 8'h00);
    $display("test registers done");
    ramp(8'h00, 8'h45, 1'b0, 8'h45, 3);
    ramp(8'h05, 8'h30, 1'b0, 8'h30, 12);
    ramp(8'ha0, 8'h34, 1'b0, 8'h34, 8);
    ramp(8'h0c, 8'h10, 1'b0, 8'h10, 1);
    ramp(8'hc0, 8'hff, 1'b0, 8'hff, 1);
    ramp(8'h33, 8'h30, 1'b0, 8'h30, 207);
    rd(12'h180, 8'h40);
    check("irq", {31'h0, irq_o}, 32'h1);
    apb(1'b1, 12'h180, 8'h40);
    repeat (2) @(posedge sys_clk_i);
    check("irq", {31'h0, irq_o}, 32'h0);
    $display("test ramps done");
    apb(1'b1, 12'h13c, 8'h00);
    ramp(8'h33, 8'h30, 1'b1, 8'hff, 26);
    ramp(8'h33, 8'h30, 1'b0, 8'h30, 207);
    $display("test emergency done");
    flags(6'h2d, 10'd64, 4'h9, 8'h00, 8'h2a);
    flags(6'h1d, 10'd64, 4'h9, 8'h00, 8'h1a);
    flags(6'h09, 10'd64, 4'h9, 8'h00, 8'h02);
    flags(6'h0f, 10'd64, 4'h9, 8'h00, 8'h0e);
    // a missing bit clock keeps an emergency ramp running: freeze it
    ce_i <= 1'b0;
    @(posedge sys_clk_i);
    vfrz = volume_code_o;
    repeat (40) @(posedge sys_clk_i);
    check("frozen volume", {24'h0, volume_code_o}, {24'h0, vfrz});
    check("frozen ramp", {31'h0, ramp_active_o}, 32'h1);
    ce_i <= 1'b1;
    @(posedge sys_clk_i);
    flags(6'h0d, 10'd512, 4'h9, 8'h00, 8'h0a);
    flags(6'h0d, 10'd513, 4'h9, 8'h00, 8'h08);
    flags(6'h0d, 10'd32, 4'h9, 8'h00, 8'h0a);
    flags(6'h0d, 10'd31, 4'h9, 8'h00, 8'h08);
    flags(6'h0c, 10'd64, 4'h9, 8'h00, 8'h08);
    flags(6'h0d, 10'd64, 4'h0, 8'h00, 8'h0b);
    flags(6'h0d, 10'd64, 4'h9, 8'h06, 8'h0b);
    flags(6'h0d, 10'd64, 4'h9, 8'h09, 8'h0a);
    flags(6'h0d, 10'd64, 4'h9, 8'h16, 8'h0b);
    flags(6'h0d, 10'd64, 4'h9, 8'h00, 8'h0a);
    apb(1'b1, 12'h0e4, 8'hff);
    rd(12'h0e4, 8'hca);
    $display("test flags done");
    conclude();
  end
endmodule // tb
